// File: hdl/epi_pkg.sv
// Package for the external pin interrupt and pin-change block: map, fields, codes.
package epi_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 12;
	localparam int          DATA_W         = 32;
	localparam int          REG_W          = 8;
	localparam logic [1:0]  WORD_ALIGN     = 2'h0;

	// ----------------------------------------------------------------
	// register indices: byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [9:0]  IDX_GROUP_FLAGS  = 10'h01B;
	localparam logic [9:0]  IDX_EXT_FLAGS    = 10'h01C;
	localparam logic [9:0]  IDX_EXT_ENABLE   = 10'h01D;
	localparam logic [9:0]  IDX_GROUP_ENABLE = 10'h068;
	localparam logic [9:0]  IDX_LOWER_SENSE  = 10'h069;
	localparam logic [9:0]  IDX_UPPER_SENSE  = 10'h06A;
	localparam logic [9:0]  IDX_GROUP0_MASK  = 10'h06B;
	localparam logic [9:0]  IDX_GROUP1_MASK  = 10'h06C;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam int          NUM_EXT_PINS     = 8;
	localparam int          NUM_LOWER_PINS   = 4;
	localparam int          NUM_CHANGE_PINS  = 13;
	localparam int          GROUP0_PINS      = 8;
	localparam int          GROUP1_PINS      = 5;
	localparam logic [7:0]  GROUP_BITS_MASK  = 8'h03;
	localparam logic [7:0]  GROUP1_MASK_BITS = 8'h1F;
	localparam int          SENSE_W          = 2;

	// two-bit sense selection per dedicated pin
	typedef enum logic [1:0] {
		EPI_SENSE_LOW  = 2'h0,
		EPI_SENSE_ANY  = 2'h1,
		EPI_SENSE_FALL = 2'h2,
		EPI_SENSE_RISE = 2'h3
	} epi_sense_t;

	// requests presented to the cpu interrupt logic
	typedef struct packed {
		logic [1:0] group;
		logic [7:0] ext;
	} epi_req_t;

	// handler-entry acknowledges from the cpu
	typedef struct packed {
		logic [1:0] group;
		logic [7:0] ext;
	} epi_ack_t;

endpackage : epi_pkg

// File: hdl/epi_ext_irq.sv
// External pin interrupt and pin-change interrupt unit with an APB register slave.
//
// Our own choice: the APB interface to the registers.
module epi_ext_irq (
	// clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [epi_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [epi_pkg::DATA_W-1:0]    pwdata,
	output logic      [epi_pkg::DATA_W-1:0]    prdata,
	output logic                               pready,
	output logic                               pslverr,
	// pins, taken whatever their direction
	input  wire logic [epi_pkg::NUM_EXT_PINS-1:0]    ext_irq_pin,
	input  wire logic [epi_pkg::NUM_CHANGE_PINS-1:0] change_sense_pins,
	// cpu side
	input  wire logic                          global_irq_enable,
	input  wire logic                          sleep_active,
	input  wire epi_pkg::epi_ack_t             handler_entry,
	output epi_pkg::epi_req_t                  irq_req
);
	import epi_pkg::*;

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [7:0]                  ext_flags,    next_ext_flags;
	logic [7:0]                  ext_enable,   next_ext_enable;
	logic [7:0]                  lower_sense,  next_lower_sense;
	logic [7:0]                  upper_sense,  next_upper_sense;
	logic [1:0]                  group_enable, next_group_enable;
	logic [1:0]                  group_flags,  next_group_flags;
	logic [7:0]                  group0_mask,  next_group0_mask;
	logic [4:0]                  group1_mask,  next_group1_mask;
	logic [3:0]                  upper_smp,    next_upper_smp;
	logic [3:0]                  upper_prev,   next_upper_prev;
	logic [3:0]                  lower_prev,   next_lower_prev;
	logic [12:0]                 change_prev,  next_change_prev;
	epi_req_t                    next_irq_req;
	logic [DATA_W-1:0]           next_prdata;
	logic                        next_pready;
	logic                        next_pslverr;

	// ----------------------------------------------------------------
	// detection
	// ----------------------------------------------------------------
	logic [3:0]  lower_eff;
	logic [7:0]  pin_now;
	logic [7:0]  pin_old;
	logic [7:0]  level_mode;
	logic [7:0]  ext_set;
	logic [7:0]  level_active;
	logic [12:0] change_hit;
	logic [1:0]  group_set;
	logic [15:0] sense_all;

	function automatic logic edge_hit(input logic [1:0] mode, input logic now,
					  input logic old);
		logic hit;
		hit = 1'b0;
		case (epi_sense_t'(mode))
			EPI_SENSE_LOW:  hit = 1'b0;
			EPI_SENSE_ANY:  hit = now ^ old;
			EPI_SENSE_FALL: hit = old & ~now;
			EPI_SENSE_RISE: hit = ~old & now;
			default:        hit = 1'b0;
		endcase
		return hit;
	endfunction : edge_hit

	always_comb begin
		// disabled input buffer in sleep reads low; this can fake a change
		lower_eff    = pin_low_buf(ext_irq_pin[3:0], ext_enable[3:0], sleep_active);
		sense_all    = {upper_sense, lower_sense};
		// upper pins use the clocked sample, lower pins the raw pin
		pin_now      = {upper_smp, lower_eff};
		pin_old      = {upper_prev, lower_prev};
		for (int i = 0; i < NUM_EXT_PINS; i++) begin
			level_mode[i]   = (sense_all[2*i +: 2] == EPI_SENSE_LOW);
			ext_set[i]      = edge_hit(sense_all[2*i +: 2], pin_now[i], pin_old[i]);
			level_active[i] = level_mode[i] & ~pin_now[i];
		end
		change_hit   = change_sense_pins ^ change_prev;
		group_set[0] = group_enable[0] & |(change_hit[7:0] & group0_mask);
		group_set[1] = group_enable[1] & |(change_hit[12:8] & group1_mask);
	end

	function automatic logic [3:0] pin_low_buf(input logic [3:0] pin,
						   input logic [3:0] en, input logic slp);
		logic [3:0] v;
		v = pin;
		for (int i = 0; i < 4; i++) begin
			if (slp && !en[i]) begin
				v[i] = 1'b0;
			end
		end
		return v;
	endfunction : pin_low_buf

	always_comb begin
		next_upper_smp   = ext_irq_pin[7:4];
		next_upper_prev  = upper_smp;
		next_lower_prev  = lower_eff;
		next_change_prev = change_sense_pins;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_smp   <= 4'h0;
			upper_prev  <= 4'h0;
			lower_prev  <= 4'h0;
			change_prev <= 13'h0000;
		end else begin
			upper_smp   <= next_upper_smp;
			upper_prev  <= next_upper_prev;
			lower_prev  <= next_lower_prev;
			change_prev <= next_change_prev;
		end
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic       bus_setup;
	logic       bus_write;
	logic [9:0] reg_idx;
	logic       reg_hit;

	always_comb begin
		reg_idx   = paddr[ADDR_W-1:2];
		bus_setup = psel & ~penable;
		bus_write = psel & penable & pready & pwrite;
		case (reg_idx)
			IDX_GROUP_FLAGS, IDX_EXT_FLAGS, IDX_EXT_ENABLE, IDX_GROUP_ENABLE,
			IDX_LOWER_SENSE, IDX_UPPER_SENSE, IDX_GROUP0_MASK,
			IDX_GROUP1_MASK: reg_hit = (paddr[1:0] == WORD_ALIGN);
			default:         reg_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_comb begin
		next_ext_enable   = ext_enable;
		next_lower_sense  = lower_sense;
		next_upper_sense  = upper_sense;
		next_group_enable = group_enable;
		next_group0_mask  = group0_mask;
		next_group1_mask  = group1_mask;
		next_ext_flags    = ext_flags & ~handler_entry.ext;
		next_group_flags  = group_flags & ~handler_entry.group;
		if (bus_write && reg_hit) begin
			case (reg_idx)
				IDX_EXT_FLAGS:    next_ext_flags   = next_ext_flags & ~pwdata[7:0];
				IDX_GROUP_FLAGS:  next_group_flags = next_group_flags & ~pwdata[1:0];
				IDX_EXT_ENABLE:   next_ext_enable  = pwdata[7:0];
				IDX_GROUP_ENABLE: next_group_enable = pwdata[1:0];
				IDX_LOWER_SENSE:  next_lower_sense = pwdata[7:0];
				IDX_UPPER_SENSE:  next_upper_sense = pwdata[7:0];
				IDX_GROUP0_MASK:  next_group0_mask = pwdata[7:0];
				IDX_GROUP1_MASK:  next_group1_mask = pwdata[4:0];
				default:          next_ext_enable  = ext_enable;
			endcase
		end
		// set wins over any clear in the same cycle; level mode forces zero
		next_ext_flags   = (next_ext_flags | ext_set) & ~level_mode;
		next_group_flags = next_group_flags | group_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_flags    <= REG_RESET;
			ext_enable   <= REG_RESET;
			lower_sense  <= REG_RESET;
			upper_sense  <= REG_RESET;
			group_enable <= 2'h0;
			group_flags  <= 2'h0;
			group0_mask  <= REG_RESET;
			group1_mask  <= 5'h00;
		end else begin
			ext_flags    <= next_ext_flags;
			ext_enable   <= next_ext_enable;
			lower_sense  <= next_lower_sense;
			upper_sense  <= next_upper_sense;
			group_enable <= next_group_enable;
			group_flags  <= next_group_flags;
			group0_mask  <= next_group0_mask;
			group1_mask  <= next_group1_mask;
		end
	end

	// ----------------------------------------------------------------
	// requests to the cpu
	// ----------------------------------------------------------------
	always_comb begin
		// output-driven pins are seen the same as inputs
		next_irq_req.ext   = {NUM_EXT_PINS{global_irq_enable}} & ext_enable &
				     (ext_flags | level_active);
		next_irq_req.group = {2{global_irq_enable}} & group_enable & group_flags;
	end

	// ----------------------------------------------------------------
	// apb answer: read data latched in setup, ready in the access cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_pready  = bus_setup;
		next_pslverr = bus_setup & ~reg_hit;
		next_prdata  = prdata;
		if (bus_setup) begin
			next_prdata = '0;
			case (reg_idx)
				IDX_GROUP_FLAGS:  next_prdata[1:0] = group_flags;
				IDX_EXT_FLAGS:    next_prdata[7:0] = ext_flags;
				IDX_EXT_ENABLE:   next_prdata[7:0] = ext_enable;
				IDX_GROUP_ENABLE: next_prdata[1:0] = group_enable;
				IDX_LOWER_SENSE:  next_prdata[7:0] = lower_sense;
				IDX_UPPER_SENSE:  next_prdata[7:0] = upper_sense;
				IDX_GROUP0_MASK:  next_prdata[7:0] = group0_mask;
				IDX_GROUP1_MASK:  next_prdata[4:0] = group1_mask;
				default:          next_prdata      = '0;
			endcase
			if (!reg_hit) begin
				next_prdata = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			irq_req <= '0;
		end else begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
			irq_req <= next_irq_req;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic wr_ext_flags;
	logic wr_grp_flags;
	assign wr_ext_flags = bus_write && reg_hit && reg_idx == IDX_EXT_FLAGS;
	assign wr_grp_flags = bus_write && reg_hit && reg_idx == IDX_GROUP_FLAGS;

	ext_req_gate_a: assert property (
		irq_req.ext[4] |-> $past(global_irq_enable && ext_enable[4]))
		else $error("upper pin request without global flag and enable");

	upper_sampled_a: assert property (
		$rose(ext_flags[5]) && $past(upper_sense[3:2] == 2'h3)
		|-> $past(upper_smp[1]) && !$past(upper_prev[1]))
		else $error("upper rising flag not from sampled values");

	pulse_caught_a: assert property (
		upper_sense[1:0] == 2'h3 && !ext_irq_pin[4] ##1 ext_irq_pin[4] &&
		upper_sense[1:0] == 2'h3 ##1 upper_sense[1:0] == 2'h3 |=> ##1 ext_flags[4])
		else $error("one-period rising pulse missed");

	level_hold_a: assert property (
		global_irq_enable && ext_enable[4] && level_mode[4] && !upper_smp[0]
		|=> irq_req.ext[4])
		else $error("low level not requesting");

	level_zero_a: assert property (
		(ext_flags & $past(level_mode)) == 8'h00)
		else $error("flag set while level sensing");

	flag_set_a: assert property (
		ext_set[6] |=> ext_flags[6])
		else $error("detected edge did not set flag");

	flag_w1c_a: assert property (
		wr_ext_flags && pwdata[0] && !ext_set[0] |=> !ext_flags[0])
		else $error("write of one did not clear flag");

	zero_write_a: assert property (
		wr_ext_flags && !pwdata[1] && ext_flags[1] && !handler_entry.ext[1]
		&& !level_mode[1] |=> ext_flags[1])
		else $error("write of zero disturbed flag");

	group_set_a: assert property (
		$rose(group_flags[0]) |-> $past(group_enable[0] &&
		|(change_hit[7:0] & group0_mask)))
		else $error("group 0 flag without unmasked change");

	group1_mask_a: assert property (
		group_enable[1] && |(change_hit[12:8] & group1_mask) |=> group_flags[1])
		else $error("group 1 change not flagged");

	group_req_a: assert property (
		irq_req.group[0] |-> $past(global_irq_enable && group_enable[0]
		&& group_flags[0]))
		else $error("group request without enables");

	group_clear_a: assert property (
		handler_entry.group[1] && !group_set[1] |=> !group_flags[1])
		else $error("handler entry did not clear group flag");

	reserved_zero_a: assert property (
		psel && penable && pready && !pwrite && !pslverr &&
		(reg_idx == IDX_GROUP_ENABLE || reg_idx == IDX_GROUP_FLAGS)
		|-> prdata[DATA_W-1:2] == '0)
		else $error("reserved bits not zero");

	apb_ready_a: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not in access cycle");

	fall_edge_a: assert property (
		$rose(ext_flags[6]) && $past(upper_sense[5:4] == 2'h2)
		|-> $past(upper_prev[2]) && !$past(upper_smp[2]))
		else $error("falling flag without falling sample");

	enable_rw_a: assert property (
		bus_write && reg_hit && reg_idx == IDX_EXT_ENABLE
		|=> ext_enable == $past(pwdata[7:0]))
		else $error("enable mask write not taken");

	group0_mask_a: assert property (
		group_enable[0] && |(change_hit[7:0] & group0_mask) |=> group_flags[0])
		else $error("group 0 change not flagged");

	lower_raw_a: assert property (
		lower_sense[1:0] == 2'h1 && !sleep_active && ext_irq_pin[0] != lower_prev[0]
		|=> ext_flags[0])
		else $error("lower pin change not flagged at once");

	change_raw_a: assert property (
		group_enable[1] && group1_mask[0] && change_sense_pins[8] != change_prev[8]
		|=> group_flags[1])
		else $error("change pin not flagged at once");

	sleep_fake_a: assert property (
		sleep_active && !ext_enable[0] && lower_prev[0] && lower_sense[1:0] == 2'h1
		|=> ext_flags[0])
		else $error("sleep buffer change did not set flag");

	cov_level_c:  cover property (irq_req.ext[7] && level_mode[7]);
	cov_any_c:    cover property (ext_set[4] && upper_sense[1:0] == 2'h1);
	cov_group1_c: cover property (irq_req.group[1]);
	cov_setwin_c: cover property (wr_ext_flags && pwdata[2] && ext_set[2]);
	cov_sleep_c:  cover property (sleep_active && ext_set[0]);

endmodule : epi_ext_irq

// File: test/epi_cpu_model.sv
// Behavioural cpu side: enters a handler for the lowest pending request.
module epi_cpu_model
	import epi_pkg::*;
#(
	parameter int ACK_GAP = 3
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// control and requests
	input  wire logic              ack_on,
	input  wire epi_pkg::epi_req_t irq_req,
	// handler entries
	output epi_pkg::epi_ack_t      handler_entry
);
	logic [9:0] pend;
	int         gap;

	assign pend = irq_req;

	// ----------------------------------------------------------------
	// vectoring
	// ----------------------------------------------------------------
	// the gap lets the cleared flag reach irq_req before the next entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			handler_entry <= '0;
			gap           <= 0;
		end else begin
			handler_entry <= '0;
			if (gap > 0) begin
				gap <= gap - 1;
			end else if (ack_on && pend != 10'h000) begin
				handler_entry <= pend & (~pend + 10'h001);
				gap           <= ACK_GAP;
			end
		end
	end
endmodule : epi_cpu_model

// File: test/test_epi_ext_irq.sv
// Self-checking bench for the external pin and pin-change interrupt unit.
module test_epi_ext_irq;
	timeunit 1ns;
	timeprecision 1ns;
	import epi_pkg::*;

	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [ADDR_W-1:0]    paddr;
	logic [DATA_W-1:0]    pwdata;
	logic [DATA_W-1:0]    prdata;
	logic                 pready;
	logic                 pslverr;
	logic [7:0]           pins;
	logic [12:0]          cpins;
	logic                 glob;
	logic                 slp;
	logic                 ack_on;
	epi_req_t             req;
	epi_ack_t             ent;
	logic [DATA_W:0]      expq[$];
	int                   miscompares;
	int                   total_checks;
	int                   seed;
	int                   m;
	logic [9:0]           idxs [8];

	initial pclk = 1'h0;
	always #25 pclk = ~pclk;

	epi_ext_irq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_irq_pin(pins), .change_sense_pins(cpins),
		.global_irq_enable(glob), .sleep_active(slp), .handler_entry(ent), .irq_req(req));

	epi_cpu_model #(.ACK_GAP(3)) cpu_u (.pclk(pclk), .presetn(presetn), .ack_on(ack_on),
		.irq_req(req), .handler_entry(ent));

	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task chk(input logic [DATA_W:0] seen, input logic [DATA_W:0] want);
		total_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk

	// read data is noted by the driver and compared here
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (expq.size() == 0) begin
				chk({pslverr, prdata}, 33'h1FFFFFFFF);
			end else begin
				chk({pslverr, prdata}, expq.pop_front());
			end
		end
	end

	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	task apb(input logic wr, input logic [9:0] idx, input logic [7:0] d,
		input logic [DATA_W:0] want);
		int n;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= {idx, 2'h0};
		pwdata  <= {24'h000000, d};
		if (!wr) expq.push_back(want);
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			end_of_test();
		end
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'h1, idx, d, 33'h000000000);
	endtask : wr

	task rd(input logic [9:0] idx, input logic [7:0] x);
		apb(1'h0, idx, 8'h00, {25'h0000000, x});
	endtask : rd

	task tick(input int k);
		repeat (k) @(posedge pclk);
	endtask : tick

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		idxs = '{IDX_GROUP_FLAGS, IDX_EXT_FLAGS, IDX_EXT_ENABLE, IDX_GROUP_ENABLE,
			IDX_LOWER_SENSE, IDX_UPPER_SENSE, IDX_GROUP0_MASK, IDX_GROUP1_MASK};
		seed    = 70411;
		presetn = 1'h0;
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = '0;
		pwdata  = '0;
		pins    = 8'h00;
		cpins   = 13'h0000;
		glob    = 1'h0;
		slp     = 1'h0;
		ack_on  = 1'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		glob    <= 1'h1;
		for (m = 0; m < 8; m++) rd(idxs[m], 8'h00);
		apb(1'h0, 10'h100, 8'h00, 33'h100000000);
		wr(IDX_GROUP_ENABLE, 8'hFF);
		rd(IDX_GROUP_ENABLE, 8'h03);
		wr(IDX_GROUP1_MASK, 8'hFF);
		rd(IDX_GROUP1_MASK, 8'h1F);
		wr(IDX_EXT_ENABLE, 8'hA5);
		rd(IDX_EXT_ENABLE, 8'hA5);
		$display("test registers done");
		for (m = 1; m < 4; m++) begin
			wr(IDX_EXT_ENABLE, 8'h00);
			wr(IDX_UPPER_SENSE, {4{m[1:0]}});
			wr(IDX_EXT_FLAGS, 8'hFF);
			pins <= 8'hF0;
			tick(4);
			rd(IDX_EXT_FLAGS, (m != 2) ? 8'hF0 : 8'h00);
			wr(IDX_EXT_FLAGS, 8'hFF);
			pins <= 8'h00;
			tick(4);
			rd(IDX_EXT_FLAGS, (m != 3) ? 8'hF0 : 8'h00);
			wr(IDX_EXT_FLAGS, 8'hFF);
		end
		pins <= 8'hF0;
		tick(2);
		pins <= 8'h00;
		tick(4);
		rd(IDX_EXT_FLAGS, 8'hF0);
		wr(IDX_EXT_FLAGS, 8'h00);
		rd(IDX_EXT_FLAGS, 8'hF0);
		wr(IDX_EXT_ENABLE, 8'h10);
		tick(3);
		chk(33'(req.ext), 33'h000000010);
		glob <= 1'h0;
		tick(3);
		chk(33'(req.ext), 33'h000000000);
		glob   <= 1'h1;
		ack_on <= 1'h1;
		tick(6);
		ack_on <= 1'h0;
		rd(IDX_EXT_FLAGS, 8'hE0);
		$display("test upper edges done");
		wr(IDX_EXT_ENABLE, 8'h00);
		wr(IDX_UPPER_SENSE, 8'h00);
		wr(IDX_EXT_FLAGS, 8'hFF);
		wr(IDX_EXT_ENABLE, 8'hF0);
		tick(3);
		chk(33'(req.ext), 33'h0000000F0);
		rd(IDX_EXT_FLAGS, 8'h00);
		// low held across several cycles before release
		pins <= 8'hF0;
		tick(3);
		chk(33'(req.ext), 33'h000000000);
		wr(IDX_EXT_ENABLE, 8'h00);
		wr(IDX_LOWER_SENSE, 8'h55);
		pins <= 8'hF1;
		tick(3);
		rd(IDX_EXT_FLAGS, 8'h01);
		wr(IDX_EXT_FLAGS, 8'hFF);
		slp <= 1'h1;
		tick(2);
		slp <= 1'h0;
		tick(2);
		rd(IDX_EXT_FLAGS, 8'h01);
		$display("test level and lower done");
		wr(IDX_GROUP0_MASK, 8'h01);
		wr(IDX_GROUP1_MASK, 8'h01);
		wr(IDX_GROUP_FLAGS, 8'hFF);
		repeat (8) begin
			@(posedge pclk);
			cpins <= cpins ^ (13'($random(seed)) & 13'h1EFE);
		end
		tick(3);
		rd(IDX_GROUP_FLAGS, 8'h00);
		cpins <= cpins ^ 13'h0001;
		tick(3);
		rd(IDX_GROUP_FLAGS, 8'h01);
		cpins <= cpins ^ 13'h0100;
		tick(3);
		rd(IDX_GROUP_FLAGS, 8'h03);
		wr(IDX_GROUP_FLAGS, 8'h01);
		rd(IDX_GROUP_FLAGS, 8'h02);
		tick(2);
		chk(33'(req.group), 33'h000000002);
		ack_on <= 1'h1;
		tick(6);
		ack_on <= 1'h0;
		rd(IDX_GROUP_FLAGS, 8'h00);
		wr(IDX_GROUP_ENABLE, 8'h00);
		cpins <= cpins ^ 13'h0101;
		tick(3);
		rd(IDX_GROUP_FLAGS, 8'h00);
		$display("test pin change done");
		end_of_test();
	end
endmodule : test_epi_ext_irq
